// ---- extended_bus_pin_mode.sv ----
// Extended bus mode pin repurposing with an AHB-Lite register slave.
// Assumes one 50 MHz clock, synchronous pins and a bus arbiter that
// reports mastership as a level.
`include "extended_bus_pin_mode_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module extended_bus_pin_mode (
    input  wire logic                                   clk_sys,
    input  wire logic                                   sys_rst,
    input  wire logic                                   hsel,
    input  wire logic [31:0]                            haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [31:0]                            hwdata,
    input  wire logic                                   hready,
    output logic      [31:0]                            hrdata,
    output logic                                        hreadyout,
    output logic                                        hresp,
    input  wire logic                                   bus_master,
    input  wire logic                                   bus_protocol_select,
    input  wire logic                                   bus_retry_input,
    input  wire logic                                   ready_input,
    input  wire extended_bus_pin_mode_pkg::codec_out_type line_code_unit_out,
    output extended_bus_pin_mode_pkg::codec_in_type     line_code_unit_in,
    input  wire extended_bus_pin_mode_pkg::pin_in_type  codec_pins_in,
    output extended_bus_pin_mode_pkg::pin_drive_type    codec_pins_drive,
    input  wire logic                                   codec_tx_clock_pin,
    output logic                                        sync_memory_termination,
    output logic                                        bus_retry_sampled,
    output logic                                        ready_sampled,
    output logic                                        ready_sync_mode
);
    import extended_bus_pin_mode_pkg::*;

    // ********************
    // Register state
    // ********************
    logic [15:0]   data_bus_setup_config_q;
    logic [15:0]   data_bus_setup_config_d;
    logic [15:0]   secondary_bus_setup_config_q;
    logic [15:0]   secondary_bus_setup_config_d;
    logic          cfg_written_q;
    logic          wr_pend_q;
    logic [7:0]    wr_addr_q;
    logic [31:0]   hrdata_q;
    logic          ext_on;
    logic          async_sel;
    logic          retry_fall_q;
    logic          ready_fall_q;
    logic          retry_q;
    logic          ready_q;
    logic          term_q;
    codec_in_type  codec_in_q;
    pin_drive_type pins_q;
    logic          addr_ok;

    // Config bit 15 opens the extended features; async retry and termination also need bit 10 clear, async ready needs bit 10 clear alone
    assign ext_on    = data_bus_setup_config_q[`BIT_EXT_BUS_ENABLE];
    assign async_sel = ext_on
                     & ~data_bus_setup_config_q[`BIT_BUS_TIMING_SEL];
    assign addr_ok   = hsel & hready & htrans[1];

    // Word read view; status shows live pin mode state
    function automatic logic [31:0] reg_read(
        input logic [7:0]  ofs,
        input logic [15:0] cfg_v,
        input logic [15:0] cfg2_v
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (ofs)
            `OFS_DATA_BUS_SETUP:  v = {16'h0000, cfg_v};
            `OFS_SECONDARY_SETUP: v = {16'h0000, cfg2_v};
            `OFS_PIN_STATUS:      v = {27'h0000000, term_q, retry_q,
                                       bus_master, cfg_written_q, ext_on};
            default:              v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_read

    // ********************
    // AHB-Lite slave
    // ********************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Bit 14 is kept at zero whatever software writes
    always_comb begin
        data_bus_setup_config_d      = data_bus_setup_config_q;
        secondary_bus_setup_config_d = secondary_bus_setup_config_q;
        if (wr_pend_q && wr_addr_q == `OFS_DATA_BUS_SETUP) begin
            data_bus_setup_config_d = hwdata[15:0];
            data_bus_setup_config_d[`BIT_MUST_BE_ZERO] = 1'b0;
        end
        if (wr_pend_q && wr_addr_q == `OFS_SECONDARY_SETUP) begin
            secondary_bus_setup_config_d = hwdata[15:0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            data_bus_setup_config_q      <= `DATA_BUS_SETUP_RST;
            secondary_bus_setup_config_q <= `SECONDARY_SETUP_RST;
        end else begin
            data_bus_setup_config_q      <= data_bus_setup_config_d;
            secondary_bus_setup_config_q <= secondary_bus_setup_config_d;
        end
    end

    // Pins stay floating until the first config write after reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_written_q <= 1'b0;
        end else if (wr_pend_q && wr_addr_q == `OFS_DATA_BUS_SETUP) begin
            cfg_written_q <= 1'b1;
        end
    end

    // Reads use next values so a write just before is seen at once
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= reg_read(haddr[7:0], data_bus_setup_config_d,
                                 secondary_bus_setup_config_d);
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ********************
    // Pin repurposing
    // ********************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pins_q <= '{out_lvl: 4'h0, oe_n: `PIN_OE_N_IDLE};
        end else if (!cfg_written_q) begin
            pins_q <= '{out_lvl: 4'h0, oe_n: `PIN_OE_N_IDLE};
        end else if (ext_on) begin
            // Order 3..0 is tx data, loopback, rx clock, rx data
            pins_q.out_lvl <= secondary_bus_setup_config_q
                              [`EXTRA_OUT_HI:`EXTRA_OUT_LO];
            pins_q.oe_n    <= bus_master ? 4'h0 : `PIN_OE_N_IDLE;
        end else begin
            pins_q.out_lvl <= {line_code_unit_out.txd,
                               line_code_unit_out.loopback, 2'b00};
            pins_q.oe_n    <= `PIN_OE_N_CODEC;
        end
    end

    // Codec inputs are held low while their pins are repurposed
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            codec_in_q <= '0;
        end else if (ext_on || !cfg_written_q) begin
            codec_in_q <= '0;
        end else begin
            codec_in_q.rx_clock <= codec_pins_in.in_lvl[1];
            codec_in_q.rxd      <= codec_pins_in.in_lvl[0];
            codec_in_q.tx_clock <= codec_tx_clock_pin;
        end
    end

    // Termination input is never driven; only qualified here
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            term_q <= 1'b0;
        end else begin
            term_q <= cfg_written_q & ext_on & bus_master
                    & async_sel & bus_protocol_select
                    & codec_tx_clock_pin;
        end
    end

    // ********************
    // Retry and ready sampling
    // ********************
    // Falling edge capture gives half a cycle of settling on slow buses
    always_ff @(negedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            retry_fall_q <= 1'b0;
            ready_fall_q <= 1'b0;
        end else begin
            retry_fall_q <= bus_retry_input;
            ready_fall_q <= ready_input;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            retry_q <= 1'b0;
        end else begin
            retry_q <= async_sel ? retry_fall_q
                                 : bus_retry_input;
        end
    end

    // Ready path only matters while this block owns the bus
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
        end else if (bus_master) begin
            ready_q <= data_bus_setup_config_q[`BIT_BUS_TIMING_SEL]
                       ? ready_input : ready_fall_q;
        end else begin
            ready_q <= 1'b0;
        end
    end

    assign line_code_unit_in       = codec_in_q;
    assign codec_pins_drive        = pins_q;
    assign sync_memory_termination = term_q;
    assign bus_retry_sampled       = retry_q;
    assign ready_sampled           = ready_q;
    assign ready_sync_mode =
        data_bus_setup_config_q[`BIT_BUS_TIMING_SEL];

    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_float_before_cfg;
        !cfg_written_q ##1 1 |-> pins_q.oe_n == `PIN_OE_N_IDLE;
    endproperty
    a_float_before_cfg: assert property (p_float_before_cfg)
        else $error("pins driven before config write");

    property p_float_until_master;
        (cfg_written_q && ext_on && !bus_master)
            |=> pins_q.oe_n == `PIN_OE_N_IDLE;
    endproperty
    a_float_until_master: assert property (p_float_until_master)
        else $error("extra outputs driven without mastership");

    property p_extra_user_outputs_levels;
        (cfg_written_q && ext_on && bus_master) |=> pins_q.oe_n == 4'h0
            && pins_q.out_lvl == $past(secondary_bus_setup_config_q[15:12]);
    endproperty
    a_extra_user_outputs_levels: assert property (p_extra_user_outputs_levels)
        else $error("extra outputs do not follow secondary config");

    property p_codec_mode;
        (cfg_written_q && !ext_on) |=> pins_q.oe_n == `PIN_OE_N_CODEC
            && pins_q.out_lvl[3] == $past(line_code_unit_out.txd)
            && line_code_unit_in.rxd == $past(codec_pins_in.in_lvl[0]);
    endproperty
    a_codec_mode: assert property (p_codec_mode)
        else $error("codec pins not in normal service");

    property p_term_qualified;
        sync_memory_termination |-> $past(async_sel && bus_master
            && bus_protocol_select && codec_tx_clock_pin);
    endproperty
    a_term_qualified: assert property (p_term_qualified)
        else $error("termination acted outside async protocol one");

    property p_term_off_normal;
        !ext_on |=> !sync_memory_termination
            && line_code_unit_in.tx_clock == ($past(cfg_written_q)
                                              & $past(codec_tx_clock_pin));
    endproperty
    a_term_off_normal: assert property (p_term_off_normal)
        else $error("tx clock pin misused with extended mode off");

    property p_retry_fall;
        async_sel |=> bus_retry_sampled == $past(retry_fall_q);
    endproperty
    a_retry_fall: assert property (p_retry_fall)
        else $error("retry not taken from falling edge");

    property p_retry_rise;
        !ext_on |=> bus_retry_sampled == $past(bus_retry_input);
    endproperty
    a_retry_rise: assert property (p_retry_rise)
        else $error("retry not taken at rising edge");

    property p_ready_sync;
        (bus_master && data_bus_setup_config_q[10])
            |=> ready_sampled == $past(ready_input);
    endproperty
    a_ready_sync: assert property (p_ready_sync)
        else $error("sync ready path wrong");

    property p_ready_async;
        (bus_master && !data_bus_setup_config_q[`BIT_BUS_TIMING_SEL])
            |=> ready_sampled == $past(ready_fall_q);
    endproperty
    a_ready_async: assert property (p_ready_async)
        else $error("async ready not taken from falling edge");

    property p_ready_idle;
        !bus_master |=> !ready_sampled;
    endproperty
    a_ready_idle: assert property (p_ready_idle)
        else $error("ready sampled without mastership");

    property p_codec_in_off;
        (ext_on || !cfg_written_q) |=> line_code_unit_in == '0;
    endproperty
    a_codec_in_off: assert property (p_codec_in_off)
        else $error("codec inputs seen while pins repurposed");

    property p_term_needs_master;
        !bus_master |=> !sync_memory_termination;
    endproperty
    a_term_needs_master: assert property (p_term_needs_master)
        else $error("termination taken without mastership");

    c_codec_mode: cover property (cfg_written_q && !ext_on
                                  ##1 pins_q.oe_n == `PIN_OE_N_CODEC);
    c_ext_drive: cover property (cfg_written_q && ext_on && bus_master
                                 ##1 pins_q.oe_n == 4'h0);
    c_term_seen: cover property (sync_memory_termination);
    c_retry_fall: cover property (async_sel && retry_fall_q);

endmodule : extended_bus_pin_mode

`default_nettype wire

// ---- extended_bus_pin_mode_defines.svh ----
// Register offsets, field positions, reset values for the pin mode block.
// Assumes AHB-Lite word access; included by bare name.
`ifndef EXTENDED_BUS_PIN_MODE_DEFINES_SVH
`define EXTENDED_BUS_PIN_MODE_DEFINES_SVH

// ********************
// Register map
// ********************
`define OFS_DATA_BUS_SETUP  8'h00
`define OFS_SECONDARY_SETUP 8'h04
`define OFS_PIN_STATUS      8'h08

// ********************
// Field positions
// ********************
`define BIT_EXT_BUS_ENABLE  15
`define BIT_MUST_BE_ZERO    14
`define BIT_BUS_TIMING_SEL  10
`define EXTRA_OUT_HI        15
`define EXTRA_OUT_LO        12

// ********************
// Reset values and output enable patterns
// ********************
`define DATA_BUS_SETUP_RST  16'h0000
`define SECONDARY_SETUP_RST 16'h0000
`define PIN_OE_N_IDLE       4'hf
`define PIN_OE_N_CODEC      4'h3

`endif

// ---- extended_bus_pin_mode_pkg.sv ----
// Types shared by the pin mode block and its surroundings.
// Assumes the defines header is included where offsets are needed.
package extended_bus_pin_mode_pkg;

    // ********************
    // Carriers
    // ********************
    typedef struct packed {
        logic txd;
        logic loopback;
    } codec_out_type;

    typedef struct packed {
        logic rx_clock;
        logic rxd;
        logic tx_clock;
    } codec_in_type;

    typedef struct packed {
        logic [3:0] in_lvl;
    } pin_in_type;

    typedef struct packed {
        logic [3:0] out_lvl;
        logic [3:0] oe_n;
    } pin_drive_type;

endpackage : extended_bus_pin_mode_pkg

// ---- bus_slave_model.sv ----
// Behavioural system bus slave facing the pin mode block.
// Assumes one bus clock; the bench picks wait states, retry and termination.
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
    input  wire logic       clk_sys,
    input  wire logic       bus_master,
    input  wire logic [1:0] wait_cycles,
    input  wire logic       retry_cmd,
    input  wire logic       term_lvl,
    output logic            ready_input,
    output logic            bus_retry_input,
    output logic            codec_tx_clock_pin
);
    // ********************
    // Ready and lines
    // ********************
    logic [1:0] cnt_q = 2'h0;
    logic       toggle_q = 1'b0;

    always_ff @(posedge clk_sys) begin
        cnt_q    <= bus_master ? cnt_q + 2'h1 : 2'h0;
        toggle_q <= ~toggle_q;
    end

    // Not addressed: ready line is released, so it wanders
    assign ready_input = bus_master ? (cnt_q == wait_cycles) : toggle_q;
    assign codec_tx_clock_pin = term_lvl;

    // Retry pulse straddles only the falling edge, so the two
    // sampling edges see different values
    initial begin
        bus_retry_input = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (retry_cmd) begin
                #4 bus_retry_input = 1'b1;
                @(negedge clk_sys);
                #4 bus_retry_input = 1'b0;
            end
        end
    end
endmodule : bus_slave_model

`default_nettype wire

// ---- extended_bus_pin_mode_tb.sv ----
// Self-checking bench for the extended bus pin mode block.
// Assumes zero-wait AHB-Lite slave and the partner model beside it.
`include "extended_bus_pin_mode_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module extended_bus_pin_mode_tb;
    import extended_bus_pin_mode_pkg::*;
    // ********************
    // Signals
    // ********************
    logic          clk_sys = 1'b0;
    logic          sys_rst = 1'b1;
    logic          hsel = 1'b0, hwrite = 1'b0, bus_master = 1'b0;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]    htrans = 2'h0, wait_cycles = 2'h0;
    logic          hreadyout, hresp, prot = 1'b1, retry_cmd = 1'b0;
    logic          ready_input, bus_retry_input, tx_pin, term_lvl = 1'b1;
    logic          term, retry_s, ready_s, sync_m;
    codec_out_type lcu_out = 2'b10;
    codec_in_type  lcu_in;
    pin_in_type    pins_in = 4'b0110;
    pin_drive_type drv;
    int            fails = 0, n_tests = 0, cyc = 0;
    logic [31:0]   r;
    logic          s;

    always #10 clk_sys = ~clk_sys;

    extended_bus_pin_mode u_extended_bus_pin_mode (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .bus_master(bus_master), .bus_protocol_select(prot),
        .bus_retry_input(bus_retry_input), .ready_input(ready_input),
        .line_code_unit_out(lcu_out), .line_code_unit_in(lcu_in),
        .codec_pins_in(pins_in), .codec_pins_drive(drv),
        .codec_tx_clock_pin(tx_pin), .sync_memory_termination(term),
        .bus_retry_sampled(retry_s), .ready_sampled(ready_s),
        .ready_sync_mode(sync_m));

    bus_slave_model u_bus_slave_model (
        .clk_sys(clk_sys), .bus_master(bus_master),
        .wait_cycles(wait_cycles), .retry_cmd(retry_cmd),
        .term_lvl(term_lvl), .ready_input(ready_input),
        .bus_retry_input(bus_retry_input), .codec_tx_clock_pin(tx_pin));

    // ********************
    // Shared tasks
    // ********************
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Master holds each phase until hready is seen high
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [15:0] d, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {16'h0, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    // Records whether a sampled flag was seen high at any of n cycle samples
    task automatic scan(input int n, input bit rdy, output logic sn);
        sn = 1'b0;
        repeat (n) begin
            settle(1);
            sn = sn | (rdy ? ready_s : retry_s);
        end
    endtask : scan

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        chk("oe_n", drv.oe_n, 4'hf);
        chk("lcu_in", lcu_in, 3'h0);
        chk("term", term, 1'b0);
        chk("hresp", hresp, 1'b0);
        ahb(`OFS_DATA_BUS_SETUP, 1'b0, 16'h0, r);
        chk("cfg", r, 32'h0);
        ahb(8'h0c, 1'b1, 16'h1234, r);
        ahb(8'h0c, 1'b0, 16'h0, r);
        chk("unmapped", r, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_normal;
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, 16'h0000, r);
        settle(2);
        chk("oe_n", drv.oe_n, `PIN_OE_N_CODEC);
        chk("out", drv.out_lvl[3:2], 2'b10);
        chk("lcu_in", lcu_in, 3'b101);
        chk("term", term, 1'b0);
        // Swapped levels expose crossed pin order
        @(posedge clk_sys);
        pins_in <= 4'b1001;
        lcu_out <= 2'b01;
        settle(2);
        chk("out", drv.out_lvl[3:2], 2'b01);
        chk("lcu_in", lcu_in, 3'b011);
        $display("test normal done");
    endtask : t_normal

    task automatic t_ext;
        ahb(`OFS_SECONDARY_SETUP, 1'b1, 16'ha000, r);
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, 16'h8000, r);
        settle(2);
        chk("oe_n", drv.oe_n, 4'hf);
        chk("term", term, 1'b0);
        chk("lcu_in", lcu_in, 3'h0);
        @(posedge clk_sys);
        bus_master <= 1'b1;
        settle(2);
        chk("oe_n", drv.oe_n, 4'h0);
        chk("out", drv.out_lvl, 4'ha);
        // Status: termination, master, written and extended bits set
        ahb(`OFS_PIN_STATUS, 1'b0, 16'h0, r);
        chk("status", r, 32'h17);
        // Termination needs async timing, protocol one and a high pin
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            prot     <= i[0];
            term_lvl <= ~i[2];
            ahb(`OFS_DATA_BUS_SETUP, 1'b1, {5'h10, i[1], 10'h0}, r);
            settle(2);
            chk("term", term, i[0] & ~i[1] & ~i[2]);
            chk("sync", sync_m, i[1]);
        end
        // Bit 14 left clear by software; bit 15 clear drops ext mode
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, 16'h3fff, r);
        ahb(`OFS_DATA_BUS_SETUP, 1'b0, 16'h0, r);
        chk("cfg", r, 32'h3fff);
        settle(2);
        chk("oe_n", drv.oe_n, `PIN_OE_N_CODEC);
        $display("test extended done");
    endtask : t_ext

    task automatic t_retry(input logic [15:0] cfg, input logic exp);
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, cfg, r);
        settle(2);
        @(posedge clk_sys);
        retry_cmd <= 1'b1;
        @(posedge clk_sys);
        retry_cmd <= 1'b0;
        scan(4, 1'b0, s);
        chk("retry", s, exp);
        $display("test retry done");
    endtask : t_retry

    task automatic t_ready;
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, 16'h8400, r);
        wait_cycles <= 2'h2;
        scan(8, 1'b1, s);
        chk("ready sync", s, 1'b1);
        ahb(`OFS_DATA_BUS_SETUP, 1'b1, 16'h8000, r);
        wait_cycles <= 2'h0;
        scan(8, 1'b1, s);
        chk("ready async", s, 1'b1);
        @(posedge clk_sys);
        bus_master <= 1'b0;
        settle(2);
        scan(4, 1'b1, s);
        chk("ready idle", s, 1'b0);
        $display("test ready done");
    endtask : t_ready

    // Reset with mastership held: pins must float again until written
    task automatic t_rerst;
        @(posedge clk_sys);
        sys_rst    <= 1'b1;
        bus_master <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle(1);
        chk("oe_n", drv.oe_n, `PIN_OE_N_IDLE);
        chk("term", term, 1'b0);
        settle(2);
        chk("oe_n", drv.oe_n, `PIN_OE_N_IDLE);
        ahb(`OFS_DATA_BUS_SETUP, 1'b0, 16'h0, r);
        chk("cfg", r, 32'h0);
        $display("test mid reset done");
    endtask : t_rerst

    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle(1);
        t_reset();
        t_normal();
        t_retry(16'h0000, 1'b0);
        t_ext();
        t_retry(16'h8000, 1'b1);
        t_ready();
        t_rerst();
        stop_test();
    end
endmodule : extended_bus_pin_mode_tb

`default_nettype wire
